// ===== inc/input_channel_pkg.sv
// Operation
// - each channel works as plain level input or as edge event counter
// - counter mode counts rising edges, falling edges, or both, per channel
// - counter advances only while run enable is set, by config or host command
// - with filter setting zero the counter is never activated
// - power-up option decides whether the counter starts running by itself
// - with save option on, count survives a power failure and is restored
// - a reset request clears the accumulated event count
// - a configurable initial value is loaded as the starting count
// - past 4294967295 the count wraps to 0 and sets sticky overflow
// - clear-overflow request drops the sticky overflow; the count is shown whether or not overflow is set
// - with scaling on, result is count difference times gain plus offset
// - scaled result recomputed every interval in seconds, default 5 seconds
package input_channel_pkg;

	localparam int COUNT_W = 32;
	localparam int FILTER_W = 16;
	localparam int INTERVAL_W = 16;
	localparam int SYNC_STAGES = 3;
	localparam int SYNC_PINS = 2;
	localparam int PIN_SENSE = 0;
	localparam int PIN_POWER_FAIL = 1;

	localparam logic [COUNT_W-1:0] COUNT_MAX = 32'hFFFFFFFF;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h00000000;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 32'h00000001;
	localparam logic [FILTER_W-1:0] FILTER_OFF = 16'h0000;
	localparam logic [FILTER_W-1:0] FILTER_ONE = 16'h0001;
	localparam logic [INTERVAL_W-1:0] INTERVAL_ZERO = 16'h0000;
	localparam logic [INTERVAL_W-1:0] INTERVAL_ONE = 16'h0001;
	localparam logic [INTERVAL_W-1:0] INTERVAL_DEFAULT_S = 16'h0005;

	// timing: clock rate, filter unit, seconds
	localparam int CLK_HZ = 50_000_000;
	localparam int FILTER_UNIT_MS = 1;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = (CLK_HZ / 1000) * FILTER_UNIT_MS;
	localparam int PRESCALE_W = 16;
	localparam int MS_COUNT_W = 10;

	typedef enum logic {
		MODE_LEVEL,
		MODE_COUNTER
	} channel_mode_t;

	typedef enum logic [1:0] {
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} edge_sel_t;

	typedef struct packed {
		channel_mode_t mode;
		edge_sel_t edge_sel;
		logic [FILTER_W-1:0] filter_ms;
		logic run_cfg;
		logic power_up_run;
		logic save_on_loss;
		logic scale_enable;
		logic [COUNT_W-1:0] gain;
		logic [COUNT_W-1:0] offset;
		logic [INTERVAL_W-1:0] interval_s;
	} counter_cfg_t;

	typedef struct packed {
		logic run_set;
		logic run_clear;
		logic reset_count;
		logic load_init;
		logic clear_overflow;
	} counter_cmd_t;

endpackage : input_channel_pkg

// ===== hdl/input_debounce_filter.sv
`timescale 1ns/100ps
module input_debounce_filter (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// sampled input and timing
	input wire logic sample_in,
	input wire logic tick_ms_in,
	input wire logic [input_channel_pkg::FILTER_W-1:0] filter_ms_in,
	// accepted level
	output logic level_out
);
	import input_channel_pkg::*;

	logic [FILTER_W-1:0] stable_ms_reg;

	// a level differing from the accepted one must hold for the full filter time
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			level_out <= 1'b0;
			stable_ms_reg <= FILTER_OFF;
		end else if (sample_in == level_out) begin
			stable_ms_reg <= FILTER_OFF;
		end else if (filter_ms_in == FILTER_OFF) begin
			// no filtering: level passes; counting is blocked elsewhere
			level_out <= sample_in;
		end else if (tick_ms_in) begin
			if (stable_ms_reg + FILTER_ONE >= filter_ms_in) begin
				level_out <= sample_in;
				stable_ms_reg <= FILTER_OFF;
			end else begin
				stable_ms_reg <= stable_ms_reg + FILTER_ONE;
			end
		end
	end

endmodule : input_debounce_filter

// ===== hdl/input_channel_event_counter.sv
`timescale 1ns/100ps
module input_channel_event_counter #(
	parameter int MS_CYCLES_P = input_channel_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// field pins
	input wire logic sense_input_channel_in,
	input wire logic power_fail_in,
	// configuration and host commands
	input wire input_channel_pkg::counter_cfg_t cfg_in,
	input wire input_channel_pkg::counter_cmd_t cmd_in,
	input wire logic [input_channel_pkg::COUNT_W-1:0] init_value_in,
	// retained count from non-volatile store
	input wire logic restore_valid_in,
	input wire logic [input_channel_pkg::COUNT_W-1:0] restore_count_in,
	// level and counter status
	output logic level_out,
	output logic running_out,
	output logic [input_channel_pkg::COUNT_W-1:0] count_out,
	output logic overflow_out,
	// scaling result
	output logic [input_channel_pkg::COUNT_W-1:0] scaled_out,
	output logic scaled_valid_out,
	// save request toward non-volatile store
	output logic save_req_out,
	output logic [input_channel_pkg::COUNT_W-1:0] save_count_out
);
	import input_channel_pkg::*;

	typedef enum logic {
		ST_BOOT,
		ST_LIVE
	} boot_state_t;

	localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(MS_CYCLES_P - 1);
	localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = 16'h0000;
	localparam logic [PRESCALE_W-1:0] PRESCALE_ONE = 16'h0001;
	localparam logic [MS_COUNT_W-1:0] MS_LAST = MS_COUNT_W'(MS_PER_S - 1);
	localparam logic [MS_COUNT_W-1:0] MS_ZERO = 10'h000;
	localparam logic [MS_COUNT_W-1:0] MS_ONE = 10'h001;

	function automatic logic edge_hit(input edge_sel_t sel, input logic prev, input logic cur);
		logic rise;
		logic fall;
		rise = !prev && cur;
		fall = prev && !cur;
		case (sel)
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			EDGE_BOTH: edge_hit = rise || fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	boot_state_t boot_state_reg;
	logic booting;
	logic [SYNC_PINS-1:0] pins;
	logic [SYNC_PINS-1:0] sync1_reg;
	logic [SYNC_PINS-1:0] sync2_reg;
	logic [SYNC_PINS-1:0] sync3_reg;
	logic [SYNC_PINS-1:0] clean_reg;
	logic [PRESCALE_W-1:0] prescale_reg;
	logic tick_ms_reg;
	logic [MS_COUNT_W-1:0] ms_in_s_reg;
	logic tick_s_reg;
	logic [INTERVAL_W-1:0] interval_cnt_reg;
	logic filtered;
	logic level_prev_reg;
	logic run_reg;
	logic counting;
	logic event_hit;
	logic pfail_prev_reg;
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] count_next;
	logic [COUNT_W-1:0] base_reg;
	logic [COUNT_W-1:0] diff;
	logic [INTERVAL_W-1:0] interval_eff;
	logic wrap;
	logic update_due;

	assign pins = {power_fail_in, sense_input_channel_in};

	// three-stage synchronisers; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
			always_ff @(posedge clk_sys_in) begin
				if (!rst_n_in) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					sync3_reg[gi] <= 1'b0;
					clean_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= pins[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					if (sync2_reg[gi] == sync3_reg[gi]) begin
						clean_reg[gi] <= sync3_reg[gi];
					end
				end
			end
		end
	endgenerate

	// millisecond and second ticks
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			prescale_reg <= PRESCALE_ZERO;
			tick_ms_reg <= 1'b0;
		end else if (prescale_reg == PRESCALE_LAST) begin
			prescale_reg <= PRESCALE_ZERO;
			tick_ms_reg <= 1'b1;
		end else begin
			prescale_reg <= prescale_reg + PRESCALE_ONE;
			tick_ms_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			ms_in_s_reg <= MS_ZERO;
			tick_s_reg <= 1'b0;
		end else if (!cfg_in.scale_enable) begin
			// seconds restart with scaling so the first interval is a full one
			ms_in_s_reg <= MS_ZERO;
			tick_s_reg <= 1'b0;
		end else begin
			tick_s_reg <= 1'b0;
			if (tick_ms_reg) begin
				if (ms_in_s_reg == MS_LAST) begin
					ms_in_s_reg <= MS_ZERO;
					tick_s_reg <= 1'b1;
				end else begin
					ms_in_s_reg <= ms_in_s_reg + MS_ONE;
				end
			end
		end
	end

	input_debounce_filter u_filter (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.sample_in(clean_reg[PIN_SENSE]),
		.tick_ms_in(tick_ms_reg),
		.filter_ms_in(cfg_in.filter_ms),
		.level_out(filtered)
	);

	// level report is valid in both modes
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			level_out <= 1'b0;
			level_prev_reg <= 1'b0;
		end else begin
			level_out <= filtered;
			level_prev_reg <= filtered;
		end
	end

	// boot: one cycle after reset release picks up the power-up choices
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			boot_state_reg <= ST_BOOT;
		end else begin
			case (boot_state_reg)
				ST_BOOT: boot_state_reg <= ST_LIVE;
				ST_LIVE: boot_state_reg <= ST_LIVE;
				default: boot_state_reg <= ST_BOOT;
			endcase
		end
	end

	// restore and power-up run are taken in this cycle only; the scaling base is also loaded here
	assign booting = (boot_state_reg == ST_BOOT);

	// run enable: power-up choice, then host commands; set beats clear
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			run_reg <= 1'b0;
		end else if (booting) begin
			run_reg <= cfg_in.power_up_run;
		end else if (cmd_in.run_set) begin
			run_reg <= 1'b1;
		end else if (cmd_in.run_clear) begin
			run_reg <= 1'b0;
		end
	end

	// filter zero holds the counter off regardless of enables
	assign counting = (boot_state_reg == ST_LIVE) && (cfg_in.mode == MODE_COUNTER)
		&& (run_reg || cfg_in.run_cfg)
		&& (cfg_in.filter_ms != FILTER_OFF);
	assign event_hit = counting && edge_hit(cfg_in.edge_sel, level_prev_reg, filtered);
	assign wrap = event_hit && (count_reg == COUNT_MAX);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			running_out <= 1'b0;
		end else begin
			running_out <= counting;
		end
	end

	// count priority: boot restore, reset, initial load, event
	always_comb begin
		count_next = count_reg;
		if (booting) begin
			if (cfg_in.save_on_loss && restore_valid_in) begin
				count_next = restore_count_in;
			end else begin
				count_next = init_value_in;
			end
		end else if (cmd_in.reset_count) begin
			count_next = COUNT_ZERO;
		end else if (cmd_in.load_init) begin
			count_next = init_value_in;
		end else if (wrap) begin
			count_next = COUNT_ZERO;
		end else if (event_hit) begin
			count_next = count_reg + COUNT_ONE;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			count_reg <= COUNT_ZERO;
			count_out <= COUNT_ZERO;
		end else begin
			count_reg <= count_next;
			count_out <= count_next;
		end
	end

	// sticky overflow; a wrap in the clearing cycle keeps it set
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			overflow_out <= 1'b0;
		end else if (wrap) begin
			overflow_out <= 1'b1;
		end else if (cmd_in.clear_overflow) begin
			overflow_out <= 1'b0;
		end
	end

	// save the live count on a power-fail rising edge
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pfail_prev_reg <= 1'b0;
			save_req_out <= 1'b0;
			save_count_out <= COUNT_ZERO;
		end else begin
			pfail_prev_reg <= clean_reg[PIN_POWER_FAIL];
			save_req_out <= 1'b0;
			if (cfg_in.save_on_loss && clean_reg[PIN_POWER_FAIL] && !pfail_prev_reg) begin
				save_req_out <= 1'b1;
				save_count_out <= count_reg;
			end
		end
	end

	// update interval; zero seconds falls back to the default
	assign interval_eff = (cfg_in.interval_s == INTERVAL_ZERO) ? INTERVAL_DEFAULT_S : cfg_in.interval_s;
	assign update_due = tick_s_reg && (interval_cnt_reg + INTERVAL_ONE >= interval_eff);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !cfg_in.scale_enable) begin
			interval_cnt_reg <= INTERVAL_ZERO;
		end else if (update_due) begin
			interval_cnt_reg <= INTERVAL_ZERO;
		end else if (tick_s_reg) begin
			interval_cnt_reg <= interval_cnt_reg + INTERVAL_ONE;
		end
	end

	// modular difference stays right across a wrap; a reset or load restarts the base
	assign diff = count_reg - base_reg;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			base_reg <= COUNT_ZERO;
		end else if (booting || cmd_in.reset_count || cmd_in.load_init
				|| !cfg_in.scale_enable || update_due) begin
			base_reg <= count_next;
		end
	end

	// result truncated to 32 bits; large gains wrap silently
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			scaled_out <= COUNT_ZERO;
			scaled_valid_out <= 1'b0;
		end else begin
			scaled_valid_out <= 1'b0;
			if (cfg_in.scale_enable && update_due) begin
				scaled_out <= COUNT_W'(diff * cfg_in.gain + cfg_in.offset);
				scaled_valid_out <= 1'b1;
			end
		end
	end

endmodule : input_channel_event_counter

// ===== verif/input_channel_event_counter_chk.sv
`timescale 1ns/100ps
module input_channel_event_counter_chk #(
	parameter int MS_CYCLES_P = input_channel_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// inputs
	input wire logic power_fail_in,
	input wire input_channel_pkg::counter_cfg_t cfg_in,
	input wire input_channel_pkg::counter_cmd_t cmd_in,
	input wire logic [input_channel_pkg::COUNT_W-1:0] init_value_in,
	// outputs
	input wire logic level_out,
	input wire logic [input_channel_pkg::COUNT_W-1:0] count_out,
	input wire logic overflow_out,
	input wire logic [input_channel_pkg::COUNT_W-1:0] scaled_out,
	input wire logic scaled_valid_out,
	input wire logic save_req_out
);
	import input_channel_pkg::*;
	// bit 0: commands taken, bit 1: boot load already visible
	logic [1:0] up_reg;
	logic cmd_reg;
	logic calm;
	always_ff @(posedge clk_sys_in) begin
		up_reg <= rst_n_in ? {up_reg[0], 1'b1} : 2'b00;
		cmd_reg <= cmd_in.reset_count | cmd_in.load_init;
	end
	// count may only move by events here
	assign calm = up_reg[1] & ~cmd_reg;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_edge_match;
		$rose(level_out) && cfg_in.edge_sel != EDGE_FALL || $fell(level_out) && cfg_in.edge_sel != EDGE_RISE;
	endsequence
	sequence s_fail_seen;
		cfg_in.save_on_loss && $rose(power_fail_in);
	endsequence
	a_cmd_clears: assert property (up_reg[0] && cmd_in.reset_count |=> count_out == COUNT_ZERO)
		else $error("count not cleared");
	a_init_loads: assert property (up_reg[0] && cmd_in.load_init && !cmd_in.reset_count
		|=> count_out == $past(init_value_in)) else $error("initial value not loaded");
	a_edge_counts: assert property ((calm && cfg_in.mode == MODE_COUNTER && cfg_in.run_cfg
		&& cfg_in.filter_ms != FILTER_OFF) ##0 s_edge_match |-> count_out == $past(count_out) + COUNT_ONE)
		else $error("edge not counted");
	a_edge_ignored: assert property (calm && $changed(level_out) && (cfg_in.mode == MODE_LEVEL
		|| cfg_in.filter_ms == FILTER_OFF) |-> $stable(count_out)) else $error("count moved");
	a_wrap_flags: assert property (calm && $changed(count_out) && $past(count_out) == COUNT_MAX
		|-> count_out == COUNT_ZERO && overflow_out) else $error("wrap wrong");
	a_ovf_sticky: assert property (overflow_out && !(up_reg[0] && cmd_in.clear_overflow)
		&& !cmd_in.reset_count && !cmd_in.load_init |=> overflow_out) else $error("overflow dropped");
	a_ovf_clears: assert property (up_reg[0] && cmd_in.clear_overflow && count_out != COUNT_MAX
		|=> !overflow_out) else $error("overflow kept");
	a_save_pulse: assert property (s_fail_seen |-> ##[1:8] save_req_out)
		else $error("no save request");
	a_save_gated: assert property (save_req_out |-> cfg_in.save_on_loss ##1 !save_req_out)
		else $error("bad save request");
	a_scaled_held: assert property (up_reg[1] && !scaled_valid_out |-> $stable(scaled_out))
		else $error("scaled moved");
endmodule : input_channel_event_counter_chk

// ===== verif/field_switch_model.sv
`timescale 1ns/100ps
module field_switch_model (
	// clock
	input wire logic clk_sys_in,
	// pulse train request
	input wire logic go_in,
	input wire logic [7:0] pulses_in,
	input wire logic [15:0] hold_in,
	// contact
	output logic pin_out,
	output logic busy_out
);
	logic [8:0] left_reg = 9'h000;
	logic [15:0] wait_reg = 16'h0000;
	logic pin_reg = 1'b0;
	// each level held for hold_in + 1 cycles; trains end low
	always_ff @(posedge clk_sys_in) begin
		if (go_in) begin
			left_reg <= {pulses_in, 1'b0};
			wait_reg <= hold_in;
		end else if (left_reg != 9'h000) begin
			if (wait_reg == 16'h0000) begin
				pin_reg <= ~pin_reg;
				left_reg <= left_reg - 9'h001;
				wait_reg <= hold_in;
			end else begin
				wait_reg <= wait_reg - 16'h0001;
			end
		end
	end
	assign pin_out = pin_reg;
	assign busy_out = left_reg != 9'h000;
endmodule : field_switch_model

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	import input_channel_pkg::*;
	localparam int MS_P = 10;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic power_fail_in = 1'b0;
	logic restore_valid_in = 1'b0;
	logic go = 1'b0;
	logic pin;
	logic busy;
	logic [7:0] npulse = 8'h00;
	logic [15:0] hold = 16'h0040;
	logic [COUNT_W-1:0] init_value_in = COUNT_ZERO;
	logic [COUNT_W-1:0] restore_count_in = COUNT_ZERO;
	counter_cfg_t cfg_in = '0;
	counter_cmd_t cmd_in = '0;
	logic level_out, running_out, overflow_out, scaled_valid_out, save_req_out;
	logic [COUNT_W-1:0] count_out, scaled_out, save_count_out;
	integer seed = 32'h0b2daf64;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int k, n, t0;
	field_switch_model u_switch (.clk_sys_in, .go_in(go), .pulses_in(npulse), .hold_in(hold), .pin_out(pin),
		.busy_out(busy));
	input_channel_event_counter #(.MS_CYCLES_P(MS_P)) u_dut (.clk_sys_in, .rst_n_in, .sense_input_channel_in(pin),
		.power_fail_in, .cfg_in, .cmd_in, .init_value_in, .restore_valid_in, .restore_count_in, .level_out,
		.running_out, .count_out, .overflow_out, .scaled_out, .scaled_valid_out, .save_req_out, .save_count_out);
	always #10 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			results();
		end
	end
	task results;
		if (n_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	task check_word(input logic [COUNT_W-1:0] got, input logic [COUNT_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_word
	task check_flag(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask : check_flag
	function automatic logic [COUNT_W-1:0] exp_count(logic [COUNT_W-1:0] s, int c, edge_sel_t e);
		return s + COUNT_W'(e == EDGE_BOTH ? 2 * c : c);
	endfunction : exp_count
	function automatic logic [COUNT_W-1:0] exp_scaled(int c, logic [COUNT_W-1:0] g, logic [COUNT_W-1:0] o);
		return COUNT_W'(c) * g + o;
	endfunction : exp_scaled
	// config changes only under reset or just before boot, so it is static while running
	task boot(input edge_sel_t e, input logic run, input logic [FILTER_W-1:0] f);
		rst_n_in = 1'b0;
		cfg_in.edge_sel = e;
		cfg_in.run_cfg = run;
		cfg_in.filter_ms = f;
		hold = 16'(f * MS_P + 40);
		repeat (16) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_sys_in);
	endtask : boot
	task pulses(input int c);
		npulse = 8'(c);
		go = 1'b1;
		@(negedge clk_sys_in);
		go = 1'b0;
		@(negedge clk_sys_in);
		while (busy) @(negedge clk_sys_in);
		repeat (hold) @(negedge clk_sys_in);
	endtask : pulses
	task send(input counter_cmd_t c);
		cmd_in = c;
		@(negedge clk_sys_in);
		cmd_in = '0;
		repeat (2) @(negedge clk_sys_in);
	endtask : send
	task wait_for(input int lim);
		k = 0;
		while (!(save_req_out | scaled_valid_out) && k < lim) begin
			@(negedge clk_sys_in);
			k++;
		end
	endtask : wait_for
	initial begin
		cfg_in.mode = MODE_COUNTER;
		cfg_in.interval_s = INTERVAL_ONE;
		for (int i = 0; i < 3; i++) begin
			init_value_in = $random(seed);
			n = 1 + ($random(seed) & 3);
			boot(edge_sel_t'(i), 1'b1, 16'(1 + (i & 1)));
			check_word(count_out, init_value_in);
			if (i == 1) begin
				// glitches far shorter than the 2 ms filter must never be accepted
				t0 = hold;
				hold = 16'h0004;
				pulses(3);
				check_flag(level_out, 1'b0);
				check_word(count_out, init_value_in);
				hold = 16'(t0);
			end
			pulses(n);
			check_word(count_out, exp_count(init_value_in, n, edge_sel_t'(i)));
		end
		boot(EDGE_RISE, 1'b0, FILTER_ONE);
		pulses(2);
		check_word(count_out, init_value_in);
		send(5'h10);
		check_flag(running_out, 1'b1);
		pulses(2);
		check_word(count_out, exp_count(init_value_in, 2, EDGE_RISE));
		send(5'h08);
		pulses(1);
		check_word(count_out, exp_count(init_value_in, 2, EDGE_RISE));
		cfg_in.power_up_run = 1'b1;
		boot(EDGE_RISE, 1'b0, FILTER_ONE);
		pulses(1);
		check_word(count_out, exp_count(init_value_in, 1, EDGE_RISE));
		boot(EDGE_BOTH, 1'b1, FILTER_OFF);
		pulses(2);
		check_word(count_out, init_value_in);
		cfg_in.mode = MODE_LEVEL;
		boot(EDGE_BOTH, 1'b1, FILTER_ONE);
		npulse = 8'h01;
		go = 1'b1;
		@(negedge clk_sys_in);
		go = 1'b0;
		repeat (hold + 25) @(negedge clk_sys_in);
		check_flag(level_out, 1'b1);
		while (busy) @(negedge clk_sys_in);
		repeat (hold) @(negedge clk_sys_in);
		check_flag(level_out, 1'b0);
		pulses(2);
		check_word(count_out, init_value_in);
		cfg_in.mode = MODE_COUNTER;
		init_value_in = COUNT_MAX;
		boot(EDGE_RISE, 1'b1, FILTER_ONE);
		pulses(1);
		check_word(count_out, COUNT_ZERO);
		pulses(1);
		check_flag(overflow_out, 1'b1);
		send(5'h01);
		check_flag(overflow_out, 1'b0);
		check_word(count_out, COUNT_ONE);
		send(5'h02);
		check_word(count_out, COUNT_MAX);
		send(5'h04);
		check_word(count_out, COUNT_ZERO);
		cfg_in.save_on_loss = 1'b1;
		boot(EDGE_RISE, 1'b1, FILTER_ONE);
		pulses(3);
		power_fail_in = 1'b1;
		wait_for(20);
		check_flag(save_req_out, 1'b1);
		check_word(save_count_out, exp_count(init_value_in, 3, EDGE_RISE));
		power_fail_in = 1'b0;
		restore_count_in = $random(seed);
		restore_valid_in = 1'b1;
		boot(EDGE_RISE, 1'b1, FILTER_ONE);
		check_word(count_out, restore_count_in);
		cfg_in.save_on_loss = 1'b0;
		cfg_in.scale_enable = 1'b1;
		cfg_in.gain = $random(seed) & 32'h000000FF;
		cfg_in.offset = $random(seed);
		boot(EDGE_RISE, 1'b1, FILTER_ONE);
		check_word(count_out, init_value_in);
		for (int i = 0; i < 2; i++) begin
			n = 1 + ($random(seed) & 3);
			pulses(n);
			wait_for(12000);
			check_flag(scaled_valid_out, 1'b1);
			check_word(scaled_out, exp_scaled(n, cfg_in.gain, cfg_in.offset));
			if (i == 1)
				check_word(32'(cyc - t0), 32'(MS_P * MS_PER_S));
			t0 = cyc;
		end
		results();
	end
endmodule : testbench
bind input_channel_event_counter input_channel_event_counter_chk #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (.clk_sys_in,
	.rst_n_in, .power_fail_in, .cfg_in, .cmd_in, .init_value_in, .level_out, .count_out, .overflow_out,
	.scaled_out, .scaled_valid_out, .save_req_out);
